// ---- rtl/mwd_decoder.sv ----
module mwd_decoder (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Instruction word from fetch
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  // Decoded selects to execute
  output mwd_pkg::mwd_decode_type decode
);

  // ************************************************************
  // Group and operation decode
  // ************************************************************
  mwd_pkg::mwd_group_type grp;
  mwd_pkg::mwd_op_type op;
  mwd_pkg::mwd_decode_type next_decode;
  logic [31:0] w;
  logic [3:0] pri;
  logic [3:0] opc;
  logic [3:0] misc;

  assign w = instr_word;
  assign pri = w[mwd_pkg::POS_PRI_HI:mwd_pkg::POS_PRI_LO];
  assign opc = w[mwd_pkg::POS_OPC_HI:mwd_pkg::POS_OPC_LO];
  assign misc = w[mwd_pkg::POS_MISC_HI:mwd_pkg::POS_MISC_LO];

  always_comb begin
    grp = mwd_pkg::grp_undefined;
    op = mwd_pkg::op_none;
    if (w[mwd_pkg::POS_TOP_HI:mwd_pkg::POS_TOP_LO] != mwd_pkg::TOP_WIDE) begin
      grp = mwd_pkg::grp_narrow16;
    end else if (w[mwd_pkg::POS_SZ_HI:mwd_pkg::POS_SZ_LO] ==
                 mwd_pkg::SZ_BRANCH) begin
      grp = mwd_pkg::grp_wide_branch;
    end else if (pri == mwd_pkg::PRI_LDST) begin
      grp = w[mwd_pkg::POS_SEC2] ? mwd_pkg::grp_ldst_dual_excl :
                                   mwd_pkg::grp_ldst_multiple;
    end else if (pri == mwd_pkg::PRI_SHREG) begin
      grp = mwd_pkg::grp_dp_shifted_reg;
    end else if (pri[3:2] == mwd_pkg::PRI_BR_CLASS) begin
      if (w[mwd_pkg::POS_CTL]) begin
        grp = mwd_pkg::grp_branch_misc;
      end else if (!pri[0]) begin
        grp = mwd_pkg::grp_dp_modified_imm;
      end else if (!w[mwd_pkg::POS_SEC0]) begin
        grp = mwd_pkg::grp_dp_plain_imm;
      end else begin
        grp = mwd_pkg::grp_undefined;
      end
    end else if (pri == mwd_pkg::PRI_LDST_SINGLE) begin
      if (w[mwd_pkg::POS_SEC4] && !w[mwd_pkg::POS_SEC0]) begin
        grp = mwd_pkg::grp_vec_elem_ldst;
      end else begin
        grp = mwd_pkg::grp_ldst_single;
      end
    end else if (pri == mwd_pkg::PRI_DP_REG) begin
      if (!w[mwd_pkg::POS_SEC4]) begin
        grp = mwd_pkg::grp_dp_register;
      end else if (!w[mwd_pkg::POS_SEC3]) begin
        grp = mwd_pkg::grp_mul_accum_absdiff;
      end else begin
        grp = mwd_pkg::grp_long_mul_div;
      end
    end else if (w[mwd_pkg::POS_CP_OP1_HI:mwd_pkg::POS_CP_OP1_LO] ==
                 mwd_pkg::CP_OP1_SIMD) begin
      // Only the x11x primaries remain here: coprocessor space.
      // vector sub-group split
      if (!w[mwd_pkg::POS_VEC_A]) begin
        grp = mwd_pkg::grp_vec_same_length;
      end else if (w[mwd_pkg::POS_VEC_B]) begin
        grp = mwd_pkg::grp_vec_shift_imm;
      end else if (w[mwd_pkg::POS_SIZE_HI:mwd_pkg::POS_SIZE_LO] !=
                   mwd_pkg::SIZE_DOUBLE) begin
        if (w[mwd_pkg::POS_SCALAR]) begin
          grp = mwd_pkg::grp_vec_reg_scalar;
        end else begin
          grp = mwd_pkg::grp_vec_diff_length;
          case (opc)
            mwd_pkg::OPC_ADDL: op = mwd_pkg::widening_add_long;
            mwd_pkg::OPC_ADDW: op = mwd_pkg::wide_add;
            mwd_pkg::OPC_SUBL: op = mwd_pkg::widening_sub_long;
            mwd_pkg::OPC_SUBW: op = mwd_pkg::wide_sub;
            mwd_pkg::OPC_ADDHN: op = w[mwd_pkg::POS_VEC_U] ?
              mwd_pkg::round_add_narrow_high : mwd_pkg::add_narrow_high;
            mwd_pkg::OPC_ABAL: op = mwd_pkg::abs_diff_accum_long;
            mwd_pkg::OPC_SUBHN: op = w[mwd_pkg::POS_VEC_U] ?
              mwd_pkg::round_sub_narrow_high : mwd_pkg::sub_narrow_high;
            mwd_pkg::OPC_ABDL: op = mwd_pkg::abs_diff_long;
            mwd_pkg::OPC_MLAL: op = mwd_pkg::mul_accum_long;
            mwd_pkg::OPC_QMLAL: op = mwd_pkg::sat_dbl_mul_accum_long;
            mwd_pkg::OPC_MLSL: op = mwd_pkg::mul_sub_long;
            mwd_pkg::OPC_QMLSL: op = mwd_pkg::sat_dbl_mul_sub_long;
            mwd_pkg::OPC_MULL: op = mwd_pkg::long_multiply;
            mwd_pkg::OPC_QMULL: op = mwd_pkg::sat_dbl_mul_long;
            mwd_pkg::OPC_MULLP: op = mwd_pkg::long_multiply;
            default: op = mwd_pkg::op_none;
          endcase
          if (op == mwd_pkg::op_none ||
              (w[mwd_pkg::POS_VEC_U] && opc[0] && opc[3])) begin
            grp = mwd_pkg::grp_undefined;
            op = mwd_pkg::op_none;
          end
        end
      end else if (!w[mwd_pkg::POS_VEC_U]) begin
        grp = mwd_pkg::grp_vec_extract;
      end else if (!opc[3]) begin
        grp = mwd_pkg::grp_vec_misc;
        if (w[mwd_pkg::POS_MISC_SEL_HI:mwd_pkg::POS_MISC_SEL_LO] ==
            mwd_pkg::MISC_SEL_WIDE) begin
          case (misc[3:2])
            mwd_pkg::MISC_ROUND: op = misc[1] ?
              mwd_pkg::convert_round_down : mwd_pkg::convert_round_up;
            mwd_pkg::MISC_ESTIMATE: op = misc[0] ?
              mwd_pkg::recip_sqrt_estimate : mwd_pkg::reciprocal_estimate;
            mwd_pkg::MISC_CONVERT: op = mwd_pkg::float_int_convert;
            default: op = mwd_pkg::op_none;
          endcase
        end
      end else if (!opc[2]) begin
        grp = mwd_pkg::grp_vec_table;
      end else if (opc == mwd_pkg::OPC_DUP &&
                   w[mwd_pkg::POS_DUP_HI:mwd_pkg::POS_DUP_LO] ==
                   mwd_pkg::DUP_SCALAR) begin
        grp = mwd_pkg::grp_vec_dup_scalar;
        op = mwd_pkg::duplicate_scalar;
      end else begin
        grp = mwd_pkg::grp_undefined;
      end
    end else if (!w[mwd_pkg::POS_CP_OP2_HI]) begin
      grp = mwd_pkg::grp_undefined;
    end else if (w[mwd_pkg::POS_CP_TOP]) begin
      grp = mwd_pkg::grp_vec_additional;
    end else if (!w[mwd_pkg::POS_CP_OP1_HI]) begin
      grp = mwd_pkg::grp_sysreg_ldst_move64;
    end else if (w[mwd_pkg::POS_CP_OP3]) begin
      grp = mwd_pkg::grp_sysreg_move32;
    end else if (!w[mwd_pkg::POS_CP_OP2_LO]) begin
      grp = mwd_pkg::grp_fp_data_proc;
    end else begin
      grp = mwd_pkg::grp_undefined;
    end
  end

  // ************************************************************
  // Output register
  // ************************************************************
  always_comb begin
    next_decode = mwd_pkg::DECODE_RESET;
    if (instr_valid) begin
      next_decode.valid = 1'b1;
      next_decode.group = grp;
      next_decode.op = op;
      next_decode.undefined = (grp == mwd_pkg::grp_undefined);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      decode <= mwd_pkg::DECODE_RESET;
    end else begin
      decode <= next_decode;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  logic chk_wide;
  logic chk_cop;
  logic [1:0] chk_op1;
  assign chk_wide = instr_valid &&
    w[mwd_pkg::POS_TOP_HI:mwd_pkg::POS_TOP_LO] == mwd_pkg::TOP_WIDE &&
    w[mwd_pkg::POS_SZ_HI:mwd_pkg::POS_SZ_LO] != mwd_pkg::SZ_BRANCH;
  assign chk_cop = chk_wide && pri[2:1] == mwd_pkg::PRI_COP_CLASS;
  assign chk_op1 = w[mwd_pkg::POS_CP_OP1_HI:mwd_pkg::POS_CP_OP1_LO];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_cop_route;
    chk_cop && chk_op1 != mwd_pkg::CP_OP1_SIMD &&
    w[mwd_pkg::POS_CP_OP2_HI] && !w[mwd_pkg::POS_CP_TOP] && !chk_op1[1]
    |=> decode.group == mwd_pkg::grp_sysreg_ldst_move64;
  endproperty
  a_cop_route: assert property (p_cop_route) else $error("bad ldst64");

  property p_move32;
    chk_cop && chk_op1 == 2'h2 && w[mwd_pkg::POS_CP_OP2_HI] &&
    !w[mwd_pkg::POS_CP_TOP]
    |=> decode.group == ($past(w[mwd_pkg::POS_CP_OP3]) ?
        mwd_pkg::grp_sysreg_move32 :
        ($past(w[mwd_pkg::POS_CP_OP2_LO]) ? mwd_pkg::grp_undefined :
         mwd_pkg::grp_fp_data_proc));
  endproperty
  a_move32: assert property (p_move32) else $error("bad move32");

  // The move space also holds one hole with op2 high
  property p_cop_hole;
    chk_cop && chk_op1 != mwd_pkg::CP_OP1_SIMD
    |=> decode.undefined == $past(!w[mwd_pkg::POS_CP_OP2_HI] ||
        (!w[mwd_pkg::POS_CP_TOP] && chk_op1 == 2'h2 &&
         w[mwd_pkg::POS_CP_OP2_LO] && !w[mwd_pkg::POS_CP_OP3]));
  endproperty
  a_cop_hole: assert property (p_cop_hole) else $error("bad hole");

  property p_vec_split;
    chk_cop && chk_op1 == mwd_pkg::CP_OP1_SIMD && !w[mwd_pkg::POS_VEC_A]
    ##1 chk_cop && chk_op1 == mwd_pkg::CP_OP1_SIMD &&
        w[mwd_pkg::POS_VEC_A] && w[mwd_pkg::POS_VEC_B]
    |=> decode.group == mwd_pkg::grp_vec_shift_imm &&
        $past(decode.group) == mwd_pkg::grp_vec_same_length;
  endproperty
  a_vec_split: assert property (p_vec_split) else $error("bad split");

  property p_ldst;
    chk_wide && pri == mwd_pkg::PRI_LDST
    |=> decode.group == ($past(w[mwd_pkg::POS_SEC2]) ?
        mwd_pkg::grp_ldst_dual_excl : mwd_pkg::grp_ldst_multiple);
  endproperty
  a_ldst: assert property (p_ldst) else $error("bad ldst");

  property p_plain;
    chk_wide && pri[3:2] == mwd_pkg::PRI_BR_CLASS && pri[0] &&
    !w[mwd_pkg::POS_CTL] && w[mwd_pkg::POS_SEC0]
    |=> decode.undefined && decode.op == mwd_pkg::op_none;
  endproperty
  a_plain: assert property (p_plain) else $error("bad plain");

  property p_single;
    chk_wide && pri == mwd_pkg::PRI_LDST_SINGLE && w[mwd_pkg::POS_SEC0]
    |=> decode.group == mwd_pkg::grp_ldst_single;
  endproperty
  a_single: assert property (p_single) else $error("bad single");

  property p_mul;
    chk_wide && pri == mwd_pkg::PRI_DP_REG && w[mwd_pkg::POS_SEC4]
    |=> decode.group == ($past(w[mwd_pkg::POS_SEC3]) ?
        mwd_pkg::grp_long_mul_div : mwd_pkg::grp_mul_accum_absdiff);
  endproperty
  a_mul: assert property (p_mul) else $error("bad mul");

  property p_branch;
    chk_wide && pri[3:2] == mwd_pkg::PRI_BR_CLASS && w[mwd_pkg::POS_CTL]
    |=> decode.group == mwd_pkg::grp_branch_misc;
  endproperty
  a_branch: assert property (p_branch) else $error("bad branch");

  property p_narrow;
    instr_valid && !chk_wide
    |=> decode.valid && !decode.undefined &&
        decode.group inside {mwd_pkg::grp_narrow16, mwd_pkg::grp_wide_branch};
  endproperty
  a_narrow: assert property (p_narrow) else $error("bad narrow");

  property p_addl;
    decode.group == mwd_pkg::grp_vec_diff_length &&
    $past(opc) == mwd_pkg::OPC_ADDL
    |-> decode.op == mwd_pkg::widening_add_long;
  endproperty
  a_addl: assert property (p_addl) else $error("bad addl");

  property p_size;
    decode.group inside {mwd_pkg::grp_vec_diff_length,
                         mwd_pkg::grp_vec_reg_scalar}
    |-> $past(w[mwd_pkg::POS_SIZE_HI:mwd_pkg::POS_SIZE_LO]) !=
        mwd_pkg::SIZE_DOUBLE;
  endproperty
  a_size: assert property (p_size) else $error("bad size");

  property p_misc;
    decode.op == mwd_pkg::float_int_convert
    |-> $past(misc[3:2]) == mwd_pkg::MISC_CONVERT &&
        decode.group == mwd_pkg::grp_vec_misc;
  endproperty
  a_misc: assert property (p_misc) else $error("bad misc");

  property p_dup;
    decode.group == mwd_pkg::grp_vec_dup_scalar
    |-> decode.op == mwd_pkg::duplicate_scalar &&
        $past(w[mwd_pkg::POS_DUP_HI:mwd_pkg::POS_DUP_LO]) ==
        mwd_pkg::DUP_SCALAR;
  endproperty
  a_dup: assert property (p_dup) else $error("bad dup");

  property p_undef;
    decode.undefined |-> decode.op == mwd_pkg::op_none &&
      decode.group == mwd_pkg::grp_undefined;
  endproperty
  a_undef: assert property (p_undef) else $error("bad undef");

  property p_one;
    decode.valid == (decode.group != mwd_pkg::grp_none) &&
    decode.valid == ($past(instr_valid) && !$past(rst));
  endproperty
  a_one: assert property (p_one) else $error("bad select");

  c_undef: cover property (decode.undefined);
  c_addl: cover property (decode.op == mwd_pkg::widening_add_long);
  c_dup: cover property (decode.op == mwd_pkg::duplicate_scalar);
  c_fp: cover property (decode.group == mwd_pkg::grp_fp_data_proc);

endmodule

// ---- rtl/mwd_pkg.sv ----
package mwd_pkg;

  // ************************************************************
  // Field positions within the 32-bit word (first halfword high)
  // ************************************************************
  localparam int POS_TOP_HI = 31;
  localparam int POS_TOP_LO = 29;
  localparam int POS_PRI_HI = 28;
  localparam int POS_PRI_LO = 25;
  localparam int POS_SZ_HI = 28;
  localparam int POS_SZ_LO = 27;
  localparam int POS_SEC4 = 24;
  localparam int POS_SEC3 = 23;
  localparam int POS_SEC2 = 22;
  localparam int POS_SEC0 = 20;
  localparam int POS_CTL = 15;
  localparam int POS_CP_TOP = 28;
  localparam int POS_CP_OP1_HI = 25;
  localparam int POS_CP_OP1_LO = 24;
  localparam int POS_CP_OP2_HI = 11;
  localparam int POS_CP_OP2_LO = 10;
  localparam int POS_CP_OP3 = 4;
  localparam int POS_VEC_U = 28;
  localparam int POS_VEC_A = 23;
  localparam int POS_VEC_B = 4;
  localparam int POS_SIZE_HI = 21;
  localparam int POS_SIZE_LO = 20;
  localparam int POS_OPC_HI = 11;
  localparam int POS_OPC_LO = 8;
  localparam int POS_SCALAR = 6;
  localparam int POS_MISC_SEL_HI = 17;
  localparam int POS_MISC_SEL_LO = 16;
  localparam int POS_MISC_HI = 10;
  localparam int POS_MISC_LO = 7;
  localparam int POS_DUP_HI = 9;
  localparam int POS_DUP_LO = 7;

  // ************************************************************
  // Selector values
  // ************************************************************
  localparam logic [2:0] TOP_WIDE = 3'h7;
  localparam logic [1:0] SZ_BRANCH = 2'h0;
  localparam logic [3:0] PRI_LDST = 4'h4;
  localparam logic [3:0] PRI_SHREG = 4'h5;
  localparam logic [1:0] PRI_BR_CLASS = 2'h2;
  localparam logic [3:0] PRI_LDST_SINGLE = 4'hc;
  localparam logic [3:0] PRI_DP_REG = 4'hd;
  localparam logic [1:0] PRI_COP_CLASS = 2'h3;
  localparam logic [1:0] CP_OP1_SIMD = 2'h3;
  localparam logic [1:0] SIZE_DOUBLE = 2'h3;
  localparam logic [1:0] MISC_SEL_WIDE = 2'h3;
  localparam logic [1:0] MISC_ROUND = 2'h1;
  localparam logic [1:0] MISC_ESTIMATE = 2'h2;
  localparam logic [1:0] MISC_CONVERT = 2'h3;
  localparam logic [3:0] OPC_DUP = 4'hc;
  localparam logic [2:0] DUP_SCALAR = 3'h0;

  // Different-length opcodes
  localparam logic [3:0] OPC_ADDL = 4'h0;
  localparam logic [3:0] OPC_ADDW = 4'h1;
  localparam logic [3:0] OPC_SUBL = 4'h2;
  localparam logic [3:0] OPC_SUBW = 4'h3;
  localparam logic [3:0] OPC_ADDHN = 4'h4;
  localparam logic [3:0] OPC_ABAL = 4'h5;
  localparam logic [3:0] OPC_SUBHN = 4'h6;
  localparam logic [3:0] OPC_ABDL = 4'h7;
  localparam logic [3:0] OPC_MLAL = 4'h8;
  localparam logic [3:0] OPC_QMLAL = 4'h9;
  localparam logic [3:0] OPC_MLSL = 4'ha;
  localparam logic [3:0] OPC_QMLSL = 4'hb;
  localparam logic [3:0] OPC_MULL = 4'hc;
  localparam logic [3:0] OPC_QMULL = 4'hd;
  localparam logic [3:0] OPC_MULLP = 4'he;

  // ************************************************************
  // Decode result types
  // ************************************************************
  typedef enum logic [4:0] {
    grp_none, grp_narrow16, grp_wide_branch, grp_ldst_multiple,
    grp_ldst_dual_excl, grp_dp_shifted_reg, grp_branch_misc,
    grp_dp_modified_imm, grp_dp_plain_imm, grp_vec_elem_ldst,
    grp_ldst_single, grp_dp_register, grp_mul_accum_absdiff,
    grp_long_mul_div, grp_sysreg_ldst_move64, grp_sysreg_move32,
    grp_fp_data_proc, grp_vec_additional, grp_vec_same_length,
    grp_vec_shift_imm, grp_vec_diff_length, grp_vec_reg_scalar,
    grp_vec_extract, grp_vec_misc, grp_vec_table, grp_vec_dup_scalar,
    grp_undefined
  } mwd_group_type;

  typedef enum logic [4:0] {
    op_none, widening_add_long, wide_add, widening_sub_long, wide_sub,
    add_narrow_high, sub_narrow_high, round_add_narrow_high,
    round_sub_narrow_high, sat_dbl_mul_accum_long, sat_dbl_mul_sub_long,
    sat_dbl_mul_long, abs_diff_accum_long, abs_diff_long,
    mul_accum_long, mul_sub_long, long_multiply, convert_round_up,
    convert_round_down, reciprocal_estimate, recip_sqrt_estimate,
    float_int_convert, duplicate_scalar
  } mwd_op_type;

  typedef struct packed {
    logic valid;
    mwd_group_type group;
    mwd_op_type op;
    logic undefined;
  } mwd_decode_type;

  localparam mwd_decode_type DECODE_RESET = '{
    valid: 1'b0, group: grp_none, op: op_none, undefined: 1'b0
  };

endpackage

// ---- dv/mwd_fetch_model.sv ----
module mwd_fetch_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Decoded selects coming back
  input wire mwd_pkg::mwd_decode_type decode,
  // Word handed to the decoder
  output logic instr_valid,
  output logic [31:0] instr_word
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [31:0] pend[$];
  mwd_pkg::mwd_decode_type seen[$];
  logic taken;
  logic in_rst;

  initial begin
    instr_valid = 1'h0;
    instr_word = 32'h0;
    taken = 1'h0;
  end

  // ********************
  // Fetch and execute
  // ********************
  always @(posedge core_clk) begin
    // Answer for the word taken one edge earlier
    if (taken)
      seen.push_back(decode);
    taken = instr_valid && !rst;
    in_rst = rst;
    #1;
    if (in_rst || pend.size() == 0) begin
      // Scrambled so a stale word can never pass for a fresh one
      instr_valid = 1'h0;
      instr_word = ~instr_word;
    end else begin
      instr_valid = 1'h1;
      instr_word = pend.pop_front();
    end
  end
endmodule

// ---- dv/mwd_decoder_tb.sv ----
module mwd_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk;
  logic rst;
  logic instr_valid;
  logic [31:0] instr_word;
  mwd_pkg::mwd_decode_type decode;
  mwd_pkg::mwd_decode_type exp_q[$];
  int n_fail = 0;
  int n_checks = 0;

  mwd_decoder i_mwd_decoder (
    .core_clk(core_clk),
    .rst(rst),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .decode(decode)
  );

  mwd_fetch_model i_mwd_fetch_model (
    .core_clk(core_clk),
    .rst(rst),
    .decode(decode),
    .instr_valid(instr_valid),
    .instr_word(instr_word)
  );

  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end

  // ********************
  // Word builders
  // ********************
  function automatic logic [31:0] t32(input logic [3:0] p,
                                      input logic [4:0] s, input logic c);
    return {3'h7, p, s, 4'h0, c, 15'h0};
  endfunction

  // Packed as {bit 28, bits 25:24, bits 11:10, bit 4} of coprocessor space
  function automatic logic [31:0] cp(input logic [5:0] f);
    return {3'h7, f[5], 2'h3, f[4:3], 12'h0, f[2:1], 5'h0, f[0], 4'h0};
  endfunction

  // uab = {U, A, B}; lo = bits 11:7; sm = {bit 6, bits 17:16}
  function automatic logic [31:0] vw(input logic [2:0] uab,
      input logic [1:0] sz, input logic [4:0] lo, input logic [2:0] sm);
    logic [31:0] w;
    w = cp({uab[2], 2'h3, 2'h0, uab[0]});
    w[23] = uab[1];
    w[21:20] = sz;
    w[17:16] = sm[1:0];
    w[11:7] = lo;
    w[6] = sm[2];
    return w;
  endfunction

  // ********************
  // Shared tasks
  // ********************
  task put(input logic [31:0] w, input mwd_pkg::mwd_group_type g,
           input mwd_pkg::mwd_op_type o = mwd_pkg::op_none);
    mwd_pkg::mwd_decode_type e;
    e = '{1'h1, g, o, g == mwd_pkg::grp_undefined};
    i_mwd_fetch_model.pend.push_back(w);
    exp_q.push_back(e);
  endtask

  task cmp(input mwd_pkg::mwd_decode_type g,
           input mwd_pkg::mwd_decode_type e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Words go out back to back; the idle cycle after them is checked too
  task drain;
    int k;
    mwd_pkg::mwd_decode_type d;
    k = 0;
    while (i_mwd_fetch_model.seen.size() < exp_q.size() && k < 200) begin
      @(posedge core_clk);
      #2;
      k++;
    end
    while (exp_q.size() > 0) begin
      d = '0;
      if (i_mwd_fetch_model.seen.size() > 0)
        d = i_mwd_fetch_model.seen.pop_front();
      cmp(d, exp_q.pop_front());
    end
    cmp(decode, mwd_pkg::DECODE_RESET);
  endtask

  // ********************
  // Scenarios
  // ********************
  task t_top;
    put(32'hdfff_ffff, mwd_pkg::grp_narrow16);
    put(t32(4'h0, 5'h1f, 1'h1), mwd_pkg::grp_wide_branch);
    put(t32(4'h4, 5'h1b, 1'h0), mwd_pkg::grp_ldst_multiple);
    put(t32(4'h4, 5'h04, 1'h0), mwd_pkg::grp_ldst_dual_excl);
    put(t32(4'h5, 5'h00, 1'h0), mwd_pkg::grp_dp_shifted_reg);
    put(t32(4'h8, 5'h1f, 1'h1), mwd_pkg::grp_branch_misc);
    put(t32(4'ha, 5'h00, 1'h0), mwd_pkg::grp_dp_modified_imm);
    put(t32(4'h9, 5'h1e, 1'h0), mwd_pkg::grp_dp_plain_imm);
    put(t32(4'hb, 5'h01, 1'h0), mwd_pkg::grp_undefined);
    put(t32(4'hc, 5'h10, 1'h0), mwd_pkg::grp_vec_elem_ldst);
    put(t32(4'hc, 5'h11, 1'h0), mwd_pkg::grp_ldst_single);
    put(t32(4'hc, 5'h0e, 1'h0), mwd_pkg::grp_ldst_single);
    put(t32(4'hd, 5'h0f, 1'h0), mwd_pkg::grp_dp_register);
    put(t32(4'hd, 5'h17, 1'h0), mwd_pkg::grp_mul_accum_absdiff);
    put(t32(4'hd, 5'h18, 1'h0), mwd_pkg::grp_long_mul_div);
    drain;
  endtask

  task t_cop;
    put(cp(6'h18), mwd_pkg::grp_vec_same_length);
    put(cp(6'h04), mwd_pkg::grp_sysreg_ldst_move64);
    put(cp(6'h0f), mwd_pkg::grp_sysreg_ldst_move64);
    put(cp(6'h15), mwd_pkg::grp_sysreg_move32);
    put(cp(6'h17), mwd_pkg::grp_sysreg_move32);
    put(cp(6'h14), mwd_pkg::grp_fp_data_proc);
    put(cp(6'h16), mwd_pkg::grp_undefined);
    put(cp(6'h0b), mwd_pkg::grp_undefined);
    put(cp(6'h20), mwd_pkg::grp_undefined);
    put(cp(6'h33), mwd_pkg::grp_undefined);
    put(cp(6'h24), mwd_pkg::grp_vec_additional);
    put(cp(6'h37), mwd_pkg::grp_vec_additional);
    drain;
  endtask

  task t_vec;
    put(vw(3'h1, 2'h0, 5'h00, 3'h0), mwd_pkg::grp_vec_same_length);
    put(vw(3'h3, 2'h0, 5'h00, 3'h0), mwd_pkg::grp_vec_shift_imm);
    put(vw(3'h2, 2'h2, 5'h00, 3'h0), mwd_pkg::grp_vec_diff_length,
        mwd_pkg::widening_add_long);
    put(vw(3'h2, 2'h1, 5'h00, 3'h4), mwd_pkg::grp_vec_reg_scalar);
    put(vw(3'h2, 2'h3, 5'h00, 3'h4), mwd_pkg::grp_vec_extract);
    put(vw(3'h6, 2'h0, 5'h12, 3'h0), mwd_pkg::grp_undefined);
    put(vw(3'h2, 2'h0, 5'h1e, 3'h0), mwd_pkg::grp_undefined);
    drain;
  endtask

  task automatic t_diff;
    logic [3:0] opc[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h8,
                            4'ha, 4'hc, 4'he};
    mwd_pkg::mwd_op_type op[10] = '{mwd_pkg::widening_add_long,
      mwd_pkg::wide_add, mwd_pkg::widening_sub_long, mwd_pkg::wide_sub,
      mwd_pkg::abs_diff_accum_long, mwd_pkg::abs_diff_long,
      mwd_pkg::mul_accum_long, mwd_pkg::mul_sub_long,
      mwd_pkg::long_multiply, mwd_pkg::long_multiply};
    for (int i = 0; i < 10; i++)
      put(vw(3'h2, 2'h1, {opc[i], 1'h0}, 3'h0),
          mwd_pkg::grp_vec_diff_length, op[i]);
    // Narrowing forms with the rounding bit both ways, saturating forms with it clear
    put(vw(3'h2, 2'h0, 5'h08, 3'h0), mwd_pkg::grp_vec_diff_length,
        mwd_pkg::add_narrow_high);
    put(vw(3'h6, 2'h0, 5'h08, 3'h0), mwd_pkg::grp_vec_diff_length,
        mwd_pkg::round_add_narrow_high);
    put(vw(3'h2, 2'h0, 5'h0c, 3'h0), mwd_pkg::grp_vec_diff_length,
        mwd_pkg::sub_narrow_high);
    put(vw(3'h6, 2'h0, 5'h0c, 3'h0), mwd_pkg::grp_vec_diff_length,
        mwd_pkg::round_sub_narrow_high);
    put(vw(3'h2, 2'h2, 5'h12, 3'h0), mwd_pkg::grp_vec_diff_length,
        mwd_pkg::sat_dbl_mul_accum_long);
    put(vw(3'h2, 2'h2, 5'h16, 3'h0), mwd_pkg::grp_vec_diff_length,
        mwd_pkg::sat_dbl_mul_sub_long);
    put(vw(3'h2, 2'h2, 5'h1a, 3'h0), mwd_pkg::grp_vec_diff_length,
        mwd_pkg::sat_dbl_mul_long);
    drain;
  endtask

  task automatic t_misc;
    logic [3:0] mop[8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'hf};
    mwd_pkg::mwd_op_type mo[8] = '{mwd_pkg::convert_round_up,
      mwd_pkg::convert_round_up, mwd_pkg::convert_round_down,
      mwd_pkg::convert_round_down, mwd_pkg::reciprocal_estimate,
      mwd_pkg::reciprocal_estimate, mwd_pkg::float_int_convert,
      mwd_pkg::float_int_convert};
    for (int i = 0; i < 8; i++)
      put(vw(3'h6, 2'h3, {1'h0, mop[i]}, 3'h3),
          mwd_pkg::grp_vec_misc, mo[i]);
    put(vw(3'h6, 2'h3, 5'h04, 3'h1), mwd_pkg::grp_vec_misc);
    put(vw(3'h6, 2'h3, 5'h09, 3'h3), mwd_pkg::grp_vec_misc,
        mwd_pkg::recip_sqrt_estimate);
    drain;
  endtask

  task t_dup;
    put(vw(3'h6, 2'h3, 5'h18, 3'h0), mwd_pkg::grp_vec_dup_scalar,
        mwd_pkg::duplicate_scalar);
    put(vw(3'h6, 2'h3, 5'h19, 3'h0), mwd_pkg::grp_undefined);
    put(vw(3'h6, 2'h3, 5'h1a, 3'h0), mwd_pkg::grp_undefined);
    put(vw(3'h6, 2'h3, 5'h10, 3'h0), mwd_pkg::grp_vec_table);
    drain;
  endtask

  // ********************
  // Verdict
  // ********************
  task results;
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // About 65 words plus idle gaps; far below this span
  initial begin
    repeat (3000) @(posedge core_clk);
    n_fail++;
    results;
  end

  initial begin
    rst = 1'h1;
    repeat (8) @(posedge core_clk);
    #1;
    cmp(decode, mwd_pkg::DECODE_RESET);
    rst = 1'h0;
    t_top;
    t_cop;
    t_vec;
    t_diff;
    t_misc;
    t_dup;
    results;
  end
endmodule
